// ### gls_pkg.sv
// Constants, field layout and state codes of the guard lock controller.
// Assumes a 20 MHz pclk and an APB master with 32-bit data.
//
// Function
// (RL1) Power-to-unlock: command high releases the lock, low keeps it locked.
// (RL2) Power-to-lock: command high engages the lock, low releases it.
// (RL3) Lock-monitored variant: unlocking turns both safety outputs off.
// (RL4) Lock-monitored variant: relocking with actuator present re-enables outputs.
// (RL5) Closed-monitored variant: only opening the guard turns outputs off.
// (RL6) Non-critical fault with outputs on: warning, diagnostic off, outputs stay.
// (RL7) Warning lasting thirty minutes switches the safety outputs off.
// (RL8) Latched fault clears on guard opening once its cause is gone.
// (RL9) Serial build: reset bit set then cleared clears the latched fault.
// (RL10) Untaught actuator after power-up: teach mode, green off, red on, 1 Hz.
// (RL11) Ten seconds into teach: short yellow blinks at 3 Hz request power-off.
// (RL12) No power-off within five minutes: abort, five red flashes.
// (RL13) After power returns, new code is stored only on renewed detection.
// (RL14) Single-teach variant refuses teaching once a code is stored.
// (RL15) Re-teachable variant teaches without limit; new code replaces old.
// (RL16) Re-teachable variant holds outputs off ten minutes after teaching.
// (RL17) Green blinks until inhibit elapsed and new actuator detected.
// (RL18) Power loss during inhibit restarts the full inhibit period.
// (RL19) Refuse to lock while the handle sits between its end positions.
// (RL20) Monitor must blank the outputs' test pulses of about one millisecond; gls_plc blanks only drops of up to BLANK-1 pclk cycles.
// (RL21) Monitor should allow 100 ms discrepancy; needs no cross-short check. gls_plc allows only BLANK-1 pclk cycles of discrepancy.
// (RL22) Red flashes one to six times per fault; steady red internal defect.
// (RL23) All slow timing from one prescaled timebase; timers restart at power-up.
// (RL24) Warning timer runs only while the cause persists, else clears.

package gls_pkg;

	// ----------------------------------------------------------------------
	// Timebase
	// ----------------------------------------------------------------------
	localparam int CLK_HZ      = 20_000_000;
	localparam int TB_MS       = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TB_MS;
	localparam int TICK_W      = 16;
	localparam int TMR_W       = 22;

	// Times in their own units, then in timebase ticks
	localparam int T_TEACH_S      = 10;
	localparam int T_POWEROFF_MIN = 5;
	localparam int T_WARN_MIN     = 30;
	localparam int T_INHIBIT_MIN  = 10;
	localparam int TEACH_MS       = T_TEACH_S * 1000 / TB_MS;
	localparam int POWEROFF_MS    = T_POWEROFF_MIN * 60_000 / TB_MS;
	localparam int WARN_MS        = T_WARN_MIN * 60_000 / TB_MS;
	localparam int INHIBIT_MS     = T_INHIBIT_MIN * 60_000 / TB_MS;

	// Indicator rates
	localparam int F_SLOW_HZ     = 1;
	localparam int F_FAST_HZ     = 3;
	localparam int SLOW_MS       = 1000 / F_SLOW_HZ / TB_MS;
	localparam int FAST_MS       = 1000 / F_FAST_HZ / TB_MS;
	localparam int FAST_ON_MS    = 50 / TB_MS;
	localparam int SLOT_MS       = 250 / TB_MS;
	localparam int GAP_SLOTS     = 4;

	// ----------------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------------
	localparam logic [11:0] A_CTRL   = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_CODE   = 12'h008;

	localparam int C_PTL    = 0;
	localparam int C_LOCKMON = 1;
	localparam int C_SD     = 2;
	localparam int C_INDIV  = 3;
	localparam int C_SINGLE = 4;
	localparam int C_SDRST  = 5;
	localparam int CTRL_W   = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h02;

	// Fault and warning codes, equal to the red flash count except F_INT, which shows steady red
	localparam logic [2:0] F_NONE   = 3'h0;
	localparam logic [2:0] F_OUT_A  = 3'h1;
	localparam logic [2:0] F_OUT_B  = 3'h2;
	localparam logic [2:0] F_CROSS  = 3'h3;
	localparam logic [2:0] F_TEMP   = 3'h4;
	localparam logic [2:0] F_ACT    = 3'h5;
	localparam logic [2:0] F_HANDLE = 3'h6;
	localparam logic [2:0] F_INT    = 3'h7;

	typedef enum logic [2:0] {
		ST_RUN      = 3'b000,
		ST_TEACH    = 3'b001,
		ST_TEACHOFF = 3'b010,
		ST_CONFIRM  = 3'b011,
		ST_INHIBIT  = 3'b100
	} gls_st_t;

endpackage

// ### gls_ctrl.sv
// Guard lock controller: lock drive, safety outputs, warnings, teach-in
// and indicators, with an APB register slave.
// Assumes all inputs synchronous to pclk; supply_ok low models loss of the
// device supply while stored codes survive like non-volatile memory.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps

module gls_ctrl #(
	parameter int unsigned TICK_CYCLES = gls_pkg::TICK_CYCLES,
	parameter int unsigned TEACH_MS    = gls_pkg::TEACH_MS,
	parameter int unsigned POWEROFF_MS = gls_pkg::POWEROFF_MS,
	parameter int unsigned WARN_MS     = gls_pkg::WARN_MS,
	parameter int unsigned INHIBIT_MS  = gls_pkg::INHIBIT_MS,
	parameter int unsigned CODE_W      = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              supply_ok,
	input  wire logic              sol_cmd_in,
	input  wire logic              guard_closed,
	input  wire logic              lock_sensed,
	input  wire logic              actuator_present,
	input  wire logic [CODE_W-1:0] actuator_code,
	input  wire logic              handle_between,
	input  wire logic              temp_high,
	input  wire logic              ext_volt_a,
	input  wire logic              ext_volt_b,
	input  wire logic              cross_short,
	input  wire logic              internal_defect,
	output logic                   lock_drive,
	output logic                   safety_output_a,
	output logic                   safety_output_b,
	output logic                   diag_out,
	output logic                   led_green,
	output logic                   led_red,
	output logic                   led_yellow
);
	import gls_pkg::*;

	// ----------------------------------------------------------------------
	// Limits and checks
	// ----------------------------------------------------------------------
	localparam logic [TICK_W-1:0] TICK_LIM = TICK_W'(TICK_CYCLES - 1);
	localparam logic [TMR_W-1:0]  TEACH_L  = TMR_W'(TEACH_MS - 1);
	localparam logic [TMR_W-1:0]  POFF_L   = TMR_W'(POWEROFF_MS - 1);
	localparam logic [TMR_W-1:0]  WARN_L   = TMR_W'(WARN_MS - 1);
	localparam logic [TMR_W-1:0]  INHIB_L  = TMR_W'(INHIBIT_MS - 1);
	localparam logic [9:0]        SLOW_L   = 10'(SLOW_MS - 1);
	localparam logic [9:0]        SLOW_H   = 10'(SLOW_MS / 2);
	localparam logic [8:0]        FAST_L   = 9'(FAST_MS - 1);
	localparam logic [8:0]        FAST_ON  = 9'(FAST_ON_MS);
	localparam logic [7:0]        SLOT_L   = 8'(SLOT_MS - 1);

	if (TICK_CYCLES < 1 || TICK_CYCLES > 2 ** TICK_W || CODE_W < 1 ||
	    CODE_W > 16 || TEACH_MS < 1 || POWEROFF_MS < 1 || WARN_MS < 1 ||
	    INHIBIT_MS < 1 || WARN_MS > 2 ** TMR_W || INHIBIT_MS >= 2 ** TMR_W ||
	    POWEROFF_MS > 2 ** TMR_W || TEACH_MS > 2 ** TMR_W) begin : g_chk
		$error("gls_ctrl: parameter out of range");
	end

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef struct packed {
		gls_st_t           st;
		logic [TICK_W-1:0] tick;
		logic [TMR_W-1:0]  tmr;
		logic [TMR_W-1:0]  wtmr;
		logic [9:0]        slow;
		logic [8:0]        fast;
		logic [7:0]        rms;
		logic [3:0]        rslot;
		logic [CODE_W-1:0] code;
		logic              code_vld;
		logic [CODE_W-1:0] pend;
		logic              inhibit;
		logic [2:0]        fault;
		logic [2:0]        warn;
		logic              sdrst_seen;
		logic              seen;
		logic [CTRL_W-1:0] ctrl;
		logic              lock;
		logic              sa;
		logic              sb;
		logic              diag;
		logic              green;
		logic              red;
		logic              yellow;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} gls_state_t;

	gls_state_t s_q;
	gls_state_t s_d;

	// Warning cause to flash code; cross short wins over single outputs
	function automatic logic [2:0] warn_of(input logic t, input logic a,
	                                        input logic b, input logic x);
		if (x || (a && b))
			return F_CROSS;
		else if (a)
			return F_OUT_A;
		else if (b)
			return F_OUT_B;
		else if (t)
			return F_TEMP;
		else
			return F_NONE;
	endfunction

	logic              ms;
	logic              lock_cmd;
	logic              act_ok;
	logic              out_on;
	logic              apb_rd;
	logic [2:0]        cause;
	logic [2:0]        show;
	logic [3:0]        slot_end;

	// ----------------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// One-millisecond timebase shared by every slow timer [RL23]
		ms = (s_q.tick == TICK_LIM);
		s_d.tick = ms ? '0 : s_q.tick + 1'b1;
		if (ms) begin
			s_d.slow = (s_q.slow == SLOW_L) ? '0 : s_q.slow + 1'b1;
			s_d.fast = (s_q.fast == FAST_L) ? '0 : s_q.fast + 1'b1;
			s_d.rms  = (s_q.rms == SLOT_L) ? '0 : s_q.rms + 1'b1;
			if (s_q.tmr != '1)
				s_d.tmr = s_q.tmr + 1'b1;
		end

		// Lock command polarity per build [RL1] [RL2]
		lock_cmd = s_q.ctrl[C_PTL] ? sol_cmd_in : ~sol_cmd_in;

		// Actuator accepted: any one when standard coded, else stored code
		act_ok = actuator_present && (!s_q.ctrl[C_INDIV] ||
		         (s_q.code_vld && actuator_code == s_q.code));

		// Teach-in sequence
		case (s_q.st)
			ST_RUN: begin
				s_d.tmr = '0;
				if (supply_ok && !s_q.seen && actuator_present &&
				    s_q.ctrl[C_INDIV]) begin
					s_d.seen = 1'b1;
					if (act_ok) begin
						s_d.st = ST_RUN;
					end else if (s_q.ctrl[C_SINGLE] && s_q.code_vld) begin
						s_d.fault = F_ACT; // Pairing is permanent [RL14]
					end else begin
						s_d.st   = ST_TEACH; // [RL10] [RL15]
						s_d.pend = actuator_code;
					end
				end
			end
			ST_TEACH: begin
				if (!supply_ok)
					s_d.st = ST_RUN;
				else if (ms && s_q.tmr == TEACH_L) begin
					s_d.st  = ST_TEACHOFF; // [RL11]
					s_d.tmr = '0;
				end
			end
			ST_TEACHOFF: begin
				if (!supply_ok) begin
					s_d.st = ST_CONFIRM;
				end else if (ms && s_q.tmr == POFF_L) begin
					s_d.st    = ST_RUN; // Abort as wrong actuator [RL12]
					s_d.fault = F_ACT;
				end
			end
			ST_CONFIRM: begin
				// Code only becomes active on renewed detection [RL13]
				if (supply_ok && actuator_present &&
				    actuator_code == s_q.pend) begin
					s_d.code     = s_q.pend; // Old code invalid [RL15]
					s_d.code_vld = 1'b1;
					s_d.seen     = 1'b1;
					s_d.tmr      = '0;
					s_d.st       = s_q.ctrl[C_SINGLE] ? ST_RUN : ST_INHIBIT;
					s_d.inhibit  = !s_q.ctrl[C_SINGLE]; // [RL16]
				end
			end
			ST_INHIBIT: begin
				if (!supply_ok) begin
					s_d.tmr = '0; // Full period again after outage [RL18]
				end else if (s_q.tmr > INHIB_L && act_ok) begin
					s_d.st      = ST_RUN; // [RL17]
					s_d.inhibit = 1'b0;
				end
			end
			default: s_d.st = ST_RUN;
		endcase
		if (!supply_ok)
			s_d.seen = 1'b0;

		out_on = supply_ok && s_q.st == ST_RUN && !s_q.inhibit &&
		         guard_closed && act_ok && s_q.fault == F_NONE &&
		         (!s_q.ctrl[C_LOCKMON] || lock_sensed); // [RL3] [RL4] [RL5]

		// Warning only while the cause lasts; timer dies with it [RL24]
		cause = warn_of(temp_high, ext_volt_a, ext_volt_b, cross_short);
		if (cause == F_NONE || !supply_ok) begin
			s_d.warn = F_NONE;
			s_d.wtmr = '0;
		end else if (s_q.warn != F_NONE || s_q.sa) begin
			s_d.warn = cause; // [RL6]
			if (ms && s_q.warn != F_NONE) begin
				s_d.wtmr = s_q.wtmr + 1'b1;
				if (s_q.wtmr == WARN_L) begin
					s_d.fault = s_q.warn; // Delayed shutdown [RL7]
					s_d.warn  = F_NONE;
					s_d.wtmr  = '0;
				end
			end
		end

		// Fault clearing by guard opening or serial reset bit
		if (s_q.ctrl[C_SDRST])
			s_d.sdrst_seen = 1'b1;
		// A fault raised in this cycle wins over a clear
		if (s_q.fault != F_INT && cause == F_NONE &&
		    s_d.fault == s_q.fault) begin
			if (!guard_closed)
				s_d.fault = F_NONE; // [RL8]
			if (s_q.ctrl[C_SD] && s_q.sdrst_seen && !s_q.ctrl[C_SDRST])
				s_d.fault = F_NONE; // [RL9]
		end
		if (s_q.sdrst_seen && !s_q.ctrl[C_SDRST])
			s_d.sdrst_seen = 1'b0;
		if (internal_defect)
			s_d.fault = F_INT; // Immediate and not resettable

		// Lock drive refused in handle intermediate position [RL19]
		s_d.lock = supply_ok && lock_cmd && !handle_between;
		s_d.sa   = out_on;
		s_d.sb   = out_on;
		s_d.diag = out_on && s_d.warn == F_NONE &&
		           (lock_sensed || !lock_cmd); // [RL6]

		// Flash code: N pulses of one slot, then a gap [RL22]
		if (s_q.fault != F_NONE)
			show = s_q.fault;
		else if (s_q.warn != F_NONE)
			show = s_q.warn;
		else if (handle_between && lock_cmd)
			show = F_HANDLE;
		else
			show = F_NONE;
		slot_end = 4'({show, 1'b0}) + 4'(GAP_SLOTS - 1);
		if (ms && s_q.rms == SLOT_L)
			s_d.rslot = (s_q.rslot >= slot_end) ? '0 : s_q.rslot + 1'b1;
		if (show == F_INT)
			s_d.red = 1'b1;
		else
			s_d.red = show != F_NONE && !s_q.rslot[0] &&
			          s_q.rslot < 4'({show, 1'b0}); // [RL22]

		// Indicators by sequence state
		s_d.green  = supply_ok;
		s_d.yellow = 1'b0;
		case (s_q.st)
			ST_TEACH: begin
				s_d.green  = 1'b0; // [RL10]
				s_d.red    = 1'b1;
				s_d.yellow = s_q.slow < SLOW_H;
			end
			ST_TEACHOFF: begin
				s_d.green  = 1'b0;
				s_d.red    = 1'b1;
				s_d.yellow = s_q.fast < FAST_ON; // [RL11]
			end
			ST_INHIBIT:
				s_d.green = supply_ok && s_q.slow < SLOW_H; // [RL17]
			ST_RUN:
				if (s_q.fault == F_NONE && guard_closed)
					s_d.yellow = lock_sensed || s_q.slow < SLOW_H;
			default: s_d.green = 1'b0;
		endcase
		if (!supply_ok) begin
			s_d.red    = 1'b0;
			s_d.yellow = 1'b0;
		end

		// APB slave: one wait state, error on unmapped word
		apb_rd = psel && penable && !s_q.pready;
		s_d.pready  = apb_rd;
		s_d.pslverr = 1'b0;
		if (apb_rd) begin
			case (paddr)
				A_CTRL:   s_d.prdata = 32'(s_q.ctrl);
				A_STATUS: s_d.prdata = {16'h0000, s_q.wtmr[TMR_W-1:TMR_W-4],
				                        s_q.warn, s_q.fault, s_q.st,
				                        s_q.inhibit, s_q.code_vld, s_q.sa};
				A_CODE:   s_d.prdata = 32'(s_q.code);
				default: begin
					s_d.prdata  = 32'h0000_0000;
					s_d.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s_q.pready && pwrite && paddr == A_CTRL)
			s_d.ctrl = pwdata[CTRL_W-1:0];
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q      <= '0;
			s_q.st   <= ST_RUN;
			s_q.ctrl <= CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata          = s_q.prdata;
	assign pready          = s_q.pready;
	assign pslverr         = s_q.pslverr;
	assign lock_drive      = s_q.lock;
	assign safety_output_a = s_q.sa;
	assign safety_output_b = s_q.sb;
	assign diag_out        = s_q.diag;
	assign led_green       = s_q.green;
	assign led_red         = s_q.red;
	assign led_yellow      = s_q.yellow;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	property p_ptu_release;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.ctrl[C_PTL] && sol_cmd_in) |=> !lock_drive;
	endproperty
	a_ptu_release: assert property (p_ptu_release) // [RL1]
		else $error("lock engaged with unlock command high");

	property p_ptl_release;
		@(posedge pclk) disable iff (!presetn)
		(s_q.ctrl[C_PTL] && !sol_cmd_in) |=> !lock_drive;
	endproperty
	a_ptl_release: assert property (p_ptl_release) // [RL2]
		else $error("lock engaged with lock command low");

	property p_unlock_off;
		@(posedge pclk) disable iff (!presetn)
		(s_q.ctrl[C_LOCKMON] && !lock_sensed) |=> !safety_output_a &&
		!safety_output_b;
	endproperty
	a_unlock_off: assert property (p_unlock_off) // [RL3]
		else $error("outputs on while unlocked");

	property p_open_off;
		@(posedge pclk) disable iff (!presetn)
		!guard_closed |=> !safety_output_a && !safety_output_b;
	endproperty
	a_open_off: assert property (p_open_off) // [RL5]
		else $error("outputs on with guard open");

	property p_warn_diag;
		@(posedge pclk) disable iff (!presetn)
		s_q.warn != F_NONE |-> !diag_out;
	endproperty
	a_warn_diag: assert property (p_warn_diag) // [RL6]
		else $error("diagnostic output on during warning");

	property p_fault_off;
		@(posedge pclk) disable iff (!presetn)
		$changed(s_q.fault) && s_q.fault != F_NONE ##1 s_q.fault != F_NONE
		|-> !safety_output_a;
	endproperty
	a_fault_off: assert property (p_fault_off) // [RL7]
		else $error("outputs on with latched fault");

	property p_handle;
		@(posedge pclk) disable iff (!presetn)
		handle_between |=> !lock_drive;
	endproperty
	a_handle: assert property (p_handle) // [RL19]
		else $error("lock engaged with handle between positions");

	property p_teach_led;
		@(posedge pclk) disable iff (!presetn)
		s_q.st == ST_TEACH ##1 s_q.st == ST_TEACH |-> !led_green && led_red;
	endproperty
	a_teach_led: assert property (p_teach_led) // [RL10]
		else $error("teach indication wrong");

	property p_inhibit;
		@(posedge pclk) disable iff (!presetn)
		s_q.inhibit |=> !safety_output_a;
	endproperty
	a_inhibit: assert property (p_inhibit) // [RL16]
		else $error("outputs on during inhibit");

	property p_single;
		@(posedge pclk) disable iff (!presetn)
		(s_q.ctrl[C_SINGLE] && s_q.code_vld) |=> $stable(s_q.code);
	endproperty
	a_single: assert property (p_single) // [RL14]
		else $error("stored code changed in single-teach variant");

	c_teach: cover property (@(posedge pclk) disable iff (!presetn)
		s_q.st == ST_TEACH ##1 s_q.st == ST_TEACHOFF);
	c_warn: cover property (@(posedge pclk) disable iff (!presetn)
		s_q.warn != F_NONE && safety_output_a);
	c_inhibit_done: cover property (@(posedge pclk) disable iff (!presetn)
		s_q.st == ST_INHIBIT ##1 s_q.st == ST_RUN);
	c_lock: cover property (@(posedge pclk) disable iff (!presetn)
		lock_drive && safety_output_a);

endmodule

// ### gls_plc.sv
// Behavioural model of the monitoring relay that commands the lock.
// Assumes one pclk domain; requests change just after a rising edge.
`timescale 1ns/10ps

module gls_plc #(
	parameter int BLANK = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic want_lock,
	input  wire logic ptl,
	input  wire logic safety_output_a,
	input  wire logic safety_output_b,
	output logic      sol_cmd_in,
	output logic      released
);
	int low_n;

	// Command polarity depends on the build the relay is wired to
	always_comb sol_cmd_in = ptl ? want_lock : !want_lock;

	// Short test drops and channel skew are blanked, not tripped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_n <= BLANK;
			released <= 1'b0;
		end else begin
			low_n <= (safety_output_a & safety_output_b) ? 0 : low_n + 1;
			released <= (safety_output_a & safety_output_b) | (low_n + 1 < BLANK);
		end
	end
endmodule

// ### gls_ctrl_tb.sv
// Self-checking bench of the guard lock controller.
// Assumes shortened timing parameters; one tick is TK pclk cycles.
`timescale 1ns/10ps

module gls_ctrl_tb;
	import gls_pkg::*;
	localparam int TK = 4;
	localparam int TCH = 10;
	localparam int POFF = 20;
	localparam int WRN = 30;
	localparam int INH = 20;
	logic        pclk, presetn, psel, penable, pwrite, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, supply_ok, want_lock, ptl, guard_closed;
	logic        lock_sensed, act_p, handle_between, sol_cmd_in, released;
	logic        lock_drive, sa, sb, diag_out, lg, lr, ly, idef;
	logic [3:0]  cz;
	logic [7:0]  code;
	logic [7:0]  taught[$];
	int          n_errors = 0;
	int          samples_checked = 0;

	gls_ctrl #(.TICK_CYCLES(TK), .TEACH_MS(TCH), .POWEROFF_MS(POFF),
		.WARN_MS(WRN), .INHIBIT_MS(INH), .CODE_W(8)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
		.sol_cmd_in(sol_cmd_in), .guard_closed(guard_closed),
		.lock_sensed(lock_sensed), .actuator_present(act_p),
		.actuator_code(code), .handle_between(handle_between),
		.temp_high(cz[3]), .ext_volt_a(cz[0]), .ext_volt_b(cz[1]),
		.cross_short(cz[2]), .internal_defect(idef),
		.lock_drive(lock_drive), .safety_output_a(sa), .safety_output_b(sb),
		.diag_out(diag_out), .led_green(lg), .led_red(lr), .led_yellow(ly));

	gls_plc plc (.pclk(pclk), .presetn(presetn), .want_lock(want_lock),
		.ptl(ptl), .safety_output_a(sa), .safety_output_b(sb),
		.sol_cmd_in(sol_cmd_in), .released(released));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; the idle edge first keeps back-to-back calls clean
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Power cycle, then bring a fresh actuator into range
	task automatic power_present(input logic [7:0] c);
		act_p <= 1'b0;
		supply_ok <= 1'b0;
		cyc(3);
		supply_ok <= 1'b1;
		cyc(3);
		code <= c;
		act_p <= 1'b1;
		cyc(3);
	endtask

	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Far longer than the whole sequence needs
	initial begin
		#(50 * 20000);
		n_errors++;
		final_report();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ptl, handle_between, cz, act_p, idef} = '0;
		{supply_ok, want_lock, guard_closed, lock_sensed} = 4'hF;
		code = 8'($urandom(32'h31F09B53));
		act_p = 1'b1;
		cyc(10);
		presetn <= 1'b1;
		apb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, 12'hFF0, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		$display("test registers done");
		// Every build, command and handle combination
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, A_CTRL, {26'($urandom), 5'h01, i[0]});
			ptl <= i[0];
			want_lock <= i[1];
			handle_between <= i[2];
			cyc(4);
			chk(32'(lock_drive), 32'(i[1] & !i[2]));
		end
		{ptl, want_lock, handle_between} <= 3'b010;
		apb(1'b1, A_CTRL, 32'h2);
		lock_sensed <= 1'b0;
		cyc(3);
		chk(32'({sa, sb}), 32'h0);
		lock_sensed <= 1'b1;
		cyc(3);
		chk(32'({sa, sb, ly}), 32'h7);
		apb(1'b1, A_CTRL, 32'h0);
		lock_sensed <= 1'b0;
		cyc(3);
		chk(32'({sa, sb}), 32'h3);
		guard_closed <= 1'b0;
		cyc(3);
		chk(32'({sa, sb}), 32'h0);
		guard_closed <= 1'b1;
		lock_sensed <= 1'b1;
		cyc(3);
		$display("test outputs done");
		// Each warning cause, withdrawn before shutdown
		for (int i = 0; i < 4; i++) begin
			cz <= 4'(1 << i);
			cyc(3);
			chk(32'({sa, sb, diag_out}), 32'h6);
			apb(1'b0, A_STATUS, 32'h0);
			chk(32'(rd[11:9]), 32'(i + 1));
			cz <= 4'h0;
			cyc(3);
			chk(32'(diag_out), 32'h1);
		end
		cz <= 4'h8;
		cyc(WRN * TK - 8);
		chk(32'({sa, sb}), 32'h3);
		chk(32'(released), 32'h1);
		cyc(16);
		chk(32'({sa, sb}), 32'h0);
		chk(32'(released), 32'h0);
		cz <= 4'h0;
		cyc(3);
		chk(32'({sa, sb}), 32'h0);
		guard_closed <= 1'b0;
		cyc(3);
		guard_closed <= 1'b1;
		cyc(3);
		chk(32'({sa, sb}), 32'h3);
		apb(1'b1, A_CTRL, 32'h4);
		cz <= 4'h1;
		cyc(WRN * TK + 16);
		cz <= 4'h0;
		cyc(3);
		chk(32'({sa, sb}), 32'h0);
		apb(1'b1, A_CTRL, 32'h24);
		apb(1'b1, A_CTRL, 32'h4);
		cyc(3);
		chk(32'({sa, sb}), 32'h3);
		$display("test warnings done");
		// Re-teachable teach-in with a power loss during the inhibit
		apb(1'b1, A_CTRL, 32'h8);
		power_present(8'($urandom) | 8'h01);
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'({rd[5:3], lg, lr}), {27'h0, ST_TEACH, 2'b01});
		cyc(TCH * TK + 8);
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'(rd[5:3]), 32'(ST_TEACHOFF));
		taught.push_back(code);
		power_present(code);
		apb(1'b0, A_CODE, 32'h0);
		chk(32'(rd[7:0]), 32'(taught[$]));
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'({rd[5:3], sa, sb}), {27'h0, ST_INHIBIT, 2'b00});
		cyc(INH * TK / 2);
		supply_ok <= 1'b0;
		cyc(3);
		supply_ok <= 1'b1;
		cyc(INH * TK - 16);
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'(rd[5:3]), 32'(ST_INHIBIT));
		cyc(40);
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'({rd[5:3], sa, sb}), {27'h0, ST_RUN, 2'b11});
		$display("test teach done");
		// Abandoned teach, then a refused one in the single variant
		power_present(taught[$] ^ 8'hFF);
		cyc((TCH + POFF) * TK + 16);
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'({rd[8:6], rd[5:3]}), {26'h0, F_ACT, ST_RUN});
		// Clear the abort fault so the refusal below must raise it anew
		guard_closed <= 1'b0;
		cyc(3);
		guard_closed <= 1'b1;
		apb(1'b1, A_CTRL, 32'h18);
		power_present(taught[$] ^ 8'h5A);
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'({rd[8:6], rd[5:3]}), {26'h0, F_ACT, ST_RUN});
		apb(1'b0, A_CODE, 32'h0);
		chk(32'(rd[7:0]), 32'(taught[$]));
		// Internal defect latches steady red; guard opening cannot clear it
		idef <= 1'b1;
		cyc(2);
		idef <= 1'b0;
		guard_closed <= 1'b0;
		cyc(3);
		guard_closed <= 1'b1;
		cyc(3);
		apb(1'b0, A_STATUS, 32'h0);
		chk(32'({rd[8:6], sa, lr}), 32'h1D);
		$display("test refusals done");
		final_report();
	end
endmodule
